// [include/pcg_pkg.sv]
// Constants and types for the port crossbar and general-purpose I/O block
package pcg_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_PORT0_LATCH   = 8'h80;
    localparam logic [7:0] ADDR_PORT0_OUTMODE = 8'hA4;
    localparam logic [7:0] ADDR_XBAR_ONE      = 8'hE2;
    localparam logic [7:0] ADDR_PORT0_INMODE  = 8'hF1;
    localparam logic [7:0] ADDR_PORT4_LATCH   = 8'hC7;
    // Bit addresses of port 0 occupy base to base plus 7
    localparam logic [7:0] BIT_PORT0_BASE     = 8'h80;
    localparam logic [4:0] BIT_BASE_HI_MASK   = 5'h10;
    // Reset values
    localparam logic [7:0] RST_PORT0_LATCH    = 8'hFF;
    localparam logic [7:0] RST_PORT0_OUTMODE  = 8'h00;
    localparam logic [7:0] RST_XBAR_ONE       = 8'h00;
    localparam logic [7:0] RST_PORT0_INMODE   = 8'hFF;
    localparam logic [7:0] RST_PORT4_LATCH    = 8'hFF;
    localparam logic [7:0] RDATA_UNMAPPED     = 8'h00;
    // Crossbar configuration one field positions
    localparam int WEAK_PULLUP_DISABLE_POS = 7;
    localparam int CROSSBAR_ENABLE_POS     = 6;
    localparam int TIMER1_ROUTE_POS        = 5;
    localparam int TIMER0_ROUTE_POS        = 4;
    localparam int EXT_CLOCK_ROUTE_POS     = 3;
    localparam int COMPARE_SEL_LSB         = 0;
    localparam int COMPARE_SEL_W           = 3;
    localparam logic [2:0] COMPARE_SEL_MAX = 3'h5;
    localparam int PORT_W                  = 8;
    localparam int COMPARE_N               = 5;
    localparam logic [3:0] SMB_PINS        = 4'h2;
    // Crossbar pin assignment
    typedef enum logic [2:0] {
        PCG_SEL_GPIO = 3'b000,
        PCG_SEL_SDA  = 3'b001,
        PCG_SEL_SCL  = 3'b010,
        PCG_SEL_CMP  = 3'b011,
        PCG_SEL_ECI  = 3'b100,
        PCG_SEL_T0   = 3'b101,
        PCG_SEL_T1   = 3'b110
    } pcg_sel_t;
endpackage : pcg_pkg

// [core/pcg_pad_ctl.sv]
// Driver, enable and weak pull-up control of one port pin
`timescale 1ns/1ps
`default_nettype none
module pcg_pad_ctl (
    input  wire logic drive_en,
    input  wire logic data,
    input  wire logic push_pull,
    input  wire logic force_od,
    input  wire logic digital,
    input  wire logic weak_pullup_disable,
    output logic      pad_out,
    output logic      pad_oe_n,
    output logic      pull_en
);
    logic pp_eff;
    logic drive;

    // Bus pins stay open-drain whatever the mode bit says
    assign pp_eff   = push_pull & ~force_od; // R13
    assign drive    = drive_en & digital & (~data | pp_eff); // R2 R12
    assign pad_out  = data;
    assign pad_oe_n = ~drive;
    // No pull-up fighting a driven zero; saves power
    assign pull_en  = ~weak_pullup_disable & digital & ~pp_eff & ~(drive & ~data); // R1 R14
endmodule : pcg_pad_ctl
`default_nettype wire

// [core/pcg_port_xbar.sv]
// Port crossbar, port latches and register access for ports 0 and 4
// Behaviour
// R1 - Weak pull-ups on unless disabled; never on analog or push-pull pins.
// R2 - Crossbar enable low keeps crossbar off and all port 0 drivers off.
// R3 - Timer 1 input reaches a pin only when its route bit is set.
// R4 - Timer 0 input reaches a pin only when its route bit is set.
// R5 - Compare field n routes outputs 0 to n-1; values six and seven reserved.
// R6 - Pins not taken by crossbar or analog use act as general-purpose I/O.
// R7 - Port 0 latch takes byte and bit access; port 4 latch bytes only.
// R8 - A latch write is held as pin output data until next write.
// R9 - Plain port reads return sampled pin levels, even for crossbar pins.
// R10 - Read-modify-write accesses read the latch, not the pins.
// R11 - External clock route bit connects counter clock input to a pin.
// R12 - Latch zero drives low; one drives high push-pull or floats open-drain.
// R13 - Bus data and clock pins are always open-drain.
// R14 - Weak pull-up off while an open-drain output drives zero.
// R15 - Input mode one is digital, zero analog; reset leaves all digital.
// R16 - Port 4 is always plain I/O and never crossbar-assigned.
`timescale 1ns/1ps
`default_nettype none
module pcg_port_xbar (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_rmw,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [7:0]  bit_addr,
    input  wire logic        bit_wr,
    input  wire logic        bit_wdata,
    input  wire logic        bit_rd,
    input  wire logic        bit_rmw,
    output logic             bit_rdata,
    input  wire logic [7:0]  port0_pin_in,
    output logic      [7:0]  port0_pin_out,
    output logic      [7:0]  port0_pin_oe_n,
    output logic      [7:0]  port0_pullup_en,
    input  wire logic [7:0]  port4_pin_in,
    output logic      [7:0]  port4_pin_out,
    output logic      [7:0]  port4_pin_oe_n,
    output logic      [7:0]  port4_pullup_en,
    input  wire logic        smbus_route,
    input  wire logic        sda_drive_low,
    input  wire logic        scl_drive_low,
    input  wire logic [4:0]  compare_out,
    output logic             sda_in,
    output logic             scl_in,
    output logic             timer0_in,
    output logic             timer1_in,
    output logic             counter_ext_clock_in
);
    logic [7:0] port0_latch_r;
    logic [7:0] port0_output_mode_r;
    logic [7:0] port0_input_mode_r;
    logic [7:0] crossbar_config_one_r;
    logic [7:0] port4_latch_r;
    logic [15:0] pin_meta_r;
    logic [15:0] pin_sync_r;
    logic [7:0] rdata_r;
    logic       bit_rdata_r;
    logic [7:0] rdata_nxt;
    logic       weak_pullup_disable;
    logic       crossbar_enable_bit;
    logic       timer1_pin_route;
    logic       timer0_pin_route;
    logic       counter_ext_clock_route;
    logic [2:0] compare_output_route_sel;
    logic [3:0] cmp_count;
    logic [7:0] p0_digital_val;
    logic [7:0] p0_data;
    logic [7:0] p0_force_od;
    logic [7:0] cmp_pin_mask;
    logic       p0_bit_hit;

    assign weak_pullup_disable      = crossbar_config_one_r[pcg_pkg::WEAK_PULLUP_DISABLE_POS];
    assign crossbar_enable_bit      = crossbar_config_one_r[pcg_pkg::CROSSBAR_ENABLE_POS];
    assign timer1_pin_route         = crossbar_config_one_r[pcg_pkg::TIMER1_ROUTE_POS];
    assign timer0_pin_route         = crossbar_config_one_r[pcg_pkg::TIMER0_ROUTE_POS];
    assign counter_ext_clock_route  = crossbar_config_one_r[pcg_pkg::EXT_CLOCK_ROUTE_POS];
    assign compare_output_route_sel =
        crossbar_config_one_r[pcg_pkg::COMPARE_SEL_LSB +: pcg_pkg::COMPARE_SEL_W];

    ////////////////////////////////////////////////////////////////////////////
    // Crossbar assignment

    // Pin order: bus pair, compare outputs, external clock, timer 0, timer 1
    function automatic pcg_pkg::pcg_sel_t pcg_pin_sel(
        input logic [3:0] pin,
        input logic       smb,
        input logic [3:0] ncmp,
        input logic       eci,
        input logic       t0,
        input logic       t1
    );
        logic [3:0]        idx;
        pcg_pkg::pcg_sel_t sel;
        idx = pin;
        sel = pcg_pkg::PCG_SEL_GPIO;
        if (smb && idx < pcg_pkg::SMB_PINS) begin
            sel = (idx == 4'h0) ? pcg_pkg::PCG_SEL_SDA : pcg_pkg::PCG_SEL_SCL;
        end else begin
            idx = smb ? idx - pcg_pkg::SMB_PINS : idx;
            if (idx < ncmp) begin
                sel = pcg_pkg::PCG_SEL_CMP;
            end else begin
                idx = idx - ncmp;
                if (eci && idx == 4'h0) begin
                    sel = pcg_pkg::PCG_SEL_ECI; // R11
                end else begin
                    idx = eci ? idx - 4'h1 : idx;
                    if (t0 && idx == 4'h0) begin
                        sel = pcg_pkg::PCG_SEL_T0; // R4
                    end else begin
                        idx = t0 ? idx - 4'h1 : idx;
                        if (t1 && idx == 4'h0) begin
                            sel = pcg_pkg::PCG_SEL_T1; // R3
                        end
                    end
                end
            end
        end
        return sel;
    endfunction : pcg_pin_sel

    // Reserved compare selections route nothing
    assign cmp_count = (compare_output_route_sel <= pcg_pkg::COMPARE_SEL_MAX)
                     ? {1'b0, compare_output_route_sel} : 4'h0; // R5
    // Analog pins read as zero
    assign p0_digital_val = pin_sync_r[7:0] & port0_input_mode_r; // R15

    always_comb begin
        pcg_pkg::pcg_sel_t sel;
        logic [3:0]        cidx;
        sel                  = pcg_pkg::PCG_SEL_GPIO;
        cidx                 = 4'h0;
        p0_data              = port0_latch_r;
        p0_force_od          = 8'h00;
        cmp_pin_mask         = 8'h00;
        sda_in               = 1'b0;
        scl_in               = 1'b0;
        timer0_in            = 1'b0;
        timer1_in            = 1'b0;
        counter_ext_clock_in = 1'b0;
        for (int i = 0; i < pcg_pkg::PORT_W; i++) begin
            sel = crossbar_enable_bit
                ? pcg_pin_sel(4'(i), smbus_route, cmp_count, counter_ext_clock_route,
                              timer0_pin_route, timer1_pin_route)
                : pcg_pkg::PCG_SEL_GPIO; // R2
            cidx = smbus_route ? 4'(i) - pcg_pkg::SMB_PINS : 4'(i);
            case (sel)
                pcg_pkg::PCG_SEL_GPIO: p0_data[i] = port0_latch_r[i]; // R6
                pcg_pkg::PCG_SEL_SDA: begin
                    p0_data[i]     = ~sda_drive_low;
                    p0_force_od[i] = 1'b1; // R13
                    sda_in         = p0_digital_val[i];
                end
                pcg_pkg::PCG_SEL_SCL: begin
                    p0_data[i]     = ~scl_drive_low;
                    p0_force_od[i] = 1'b1; // R13
                    scl_in         = p0_digital_val[i];
                end
                pcg_pkg::PCG_SEL_CMP: begin
                    p0_data[i]      = compare_out[cidx[2:0]]; // R5
                    cmp_pin_mask[i] = 1'b1;
                end
                // Input slots output a one, releasing the pin for the outside unless its mode bit selects push-pull
                pcg_pkg::PCG_SEL_ECI: begin
                    p0_data[i]           = 1'b1;
                    counter_ext_clock_in = p0_digital_val[i]; // R11
                end
                pcg_pkg::PCG_SEL_T0: begin
                    p0_data[i] = 1'b1;
                    timer0_in  = p0_digital_val[i]; // R4
                end
                pcg_pkg::PCG_SEL_T1: begin
                    p0_data[i] = 1'b1;
                    timer1_in  = p0_digital_val[i]; // R3
                end
                default: p0_data[i] = port0_latch_r[i];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    for (genvar g = 0; g < pcg_pkg::PORT_W; g++) begin : g_pad
        pcg_pad_ctl u_p0 (
            .drive_en            (crossbar_enable_bit),
            .data                (p0_data[g]),
            .push_pull           (port0_output_mode_r[g]),
            .force_od            (p0_force_od[g]),
            .digital             (port0_input_mode_r[g]),
            .weak_pullup_disable (weak_pullup_disable),
            .pad_out             (port0_pin_out[g]),
            .pad_oe_n            (port0_pin_oe_n[g]),
            .pull_en             (port0_pullup_en[g])
        );
        // Port 4 ignores the crossbar enable; open-drain, always digital
        pcg_pad_ctl u_p4 (
            .drive_en            (1'b1),
            .data                (port4_latch_r[g]), // R16
            .push_pull           (1'b0),
            .force_od            (1'b0),
            .digital             (1'b1),
            .weak_pullup_disable (weak_pullup_disable),
            .pad_out             (port4_pin_out[g]),
            .pad_oe_n            (port4_pin_oe_n[g]),
            .pull_en             (port4_pullup_en[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= 16'h0000;
            pin_sync_r <= 16'h0000;
        end else begin
            pin_meta_r <= {port4_pin_in, port0_pin_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    assign p0_bit_hit = bit_addr[7:3] == pcg_pkg::BIT_PORT0_BASE[7:3];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port0_latch_r <= pcg_pkg::RST_PORT0_LATCH;
        end else if (sfr_wr && sfr_addr == pcg_pkg::ADDR_PORT0_LATCH) begin
            port0_latch_r <= sfr_wdata; // R7 R8
        end else if (bit_wr && p0_bit_hit) begin
            port0_latch_r[bit_addr[2:0]] <= bit_wdata; // R7 R10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port4_latch_r <= pcg_pkg::RST_PORT4_LATCH;
        end else if (sfr_wr && sfr_addr == pcg_pkg::ADDR_PORT4_LATCH) begin
            port4_latch_r <= sfr_wdata; // R7 R8
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port0_output_mode_r   <= pcg_pkg::RST_PORT0_OUTMODE;
            port0_input_mode_r    <= pcg_pkg::RST_PORT0_INMODE; // R15
            crossbar_config_one_r <= pcg_pkg::RST_XBAR_ONE;
        end else if (sfr_wr) begin
            case (sfr_addr)
                pcg_pkg::ADDR_PORT0_OUTMODE: port0_output_mode_r   <= sfr_wdata;
                pcg_pkg::ADDR_PORT0_INMODE:  port0_input_mode_r    <= sfr_wdata;
                pcg_pkg::ADDR_XBAR_ONE:      crossbar_config_one_r <= sfr_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads

    always_comb begin
        case (sfr_addr)
            pcg_pkg::ADDR_PORT0_LATCH:
                rdata_nxt = sfr_rmw ? port0_latch_r : p0_digital_val; // R9 R10
            pcg_pkg::ADDR_PORT4_LATCH:
                rdata_nxt = sfr_rmw ? port4_latch_r : pin_sync_r[15:8]; // R9 R10
            pcg_pkg::ADDR_PORT0_OUTMODE: rdata_nxt = port0_output_mode_r;
            pcg_pkg::ADDR_PORT0_INMODE:  rdata_nxt = port0_input_mode_r;
            pcg_pkg::ADDR_XBAR_ONE:      rdata_nxt = crossbar_config_one_r;
            default:                     rdata_nxt = pcg_pkg::RDATA_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r     <= 8'h00;
            bit_rdata_r <= 1'b0;
        end else begin
            if (sfr_rd) begin
                rdata_r <= rdata_nxt;
            end
            if (bit_rd) begin
                bit_rdata_r <= p0_bit_hit && (bit_rmw ? port0_latch_r[bit_addr[2:0]]
                                                      : p0_digital_val[bit_addr[2:0]]); // R10
            end
        end
    end

    assign sfr_rdata = rdata_r;
    assign bit_rdata = bit_rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    xbar_off_a: assert property (!crossbar_enable_bit |-> port0_pin_oe_n == 8'hFF) // R2
        else $error("port 0 driven while crossbar off");
    pullup_off_a: assert property (weak_pullup_disable // R1
        |-> (port0_pullup_en | port4_pullup_en) == 8'h00)
        else $error("pull-up on while disabled");
    pull_zero_a: assert property ( // R14
        (port0_pullup_en & ~port0_pin_oe_n & ~port0_pin_out) == 8'h00)
        else $error("pull-up on a driven zero");
    latch_hold_a: assert property (sfr_wr && sfr_addr == pcg_pkg::ADDR_PORT0_LATCH && !bit_wr
        ##1 !sfr_wr && !bit_wr |-> port0_latch_r == $past(sfr_wdata)) // R8
        else $error("port 0 latch lost written value");
    pin_read_a: assert property (sfr_rd && !sfr_rmw && sfr_addr == pcg_pkg::ADDR_PORT0_LATCH
        |=> sfr_rdata == ($past(pin_sync_r[7:0]) & $past(port0_input_mode_r))) // R9
        else $error("port read did not return pins");
    rmw_read_a: assert property (sfr_rd && sfr_rmw && sfr_addr == pcg_pkg::ADDR_PORT4_LATCH
        |=> sfr_rdata == $past(port4_latch_r)) // R10
        else $error("rmw read did not return latch");
    p4_bit_a: assert property (bit_wr && !sfr_wr |=> $stable(port4_latch_r)) // R7
        else $error("port 4 took a bit write");
    cmp_count_a: assert property (crossbar_enable_bit && !smbus_route
        |-> $countones(cmp_pin_mask) == 32'(cmp_count)) // R5
        else $error("wrong number of compare pins");
    timer_off_a: assert property (!timer0_pin_route && !timer1_pin_route // R3 R4
        |-> !timer0_in && !timer1_in)
        else $error("timer input reached while unrouted");
    od_bus_a: assert property ((p0_force_od & ~port0_pin_oe_n & port0_pin_out) == 8'h00) // R13
        else $error("bus pin driven high");

    xbar_on_c: cover property (crossbar_enable_bit && cmp_count == 4'h5);
    rmw_bit_c: cover property (bit_rd && bit_rmw && p0_bit_hit);
    smb_c:     cover property (crossbar_enable_bit && smbus_route && timer1_pin_route);
endmodule : pcg_port_xbar
`default_nettype wire

// [test/pcg_pin_model.sv]
// Pin-side model of one eight-pin port: drivers, pull-ups and outside world
`timescale 1ns/1ps
`default_nettype none
module pcg_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe_n,
    input  wire logic [7:0] pull,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin
);
    logic [7:0] last_r = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // Wired-AND; a line nobody holds wanders instead of keeping its value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if ((!oe_n[i] && !out[i]) || (ext_en[i] && !ext_val[i])) pin[i] = 1'b0;
            else if (!oe_n[i] || ext_en[i] || pull[i]) pin[i] = 1'b1;
            else pin[i] = ~last_r[i];
        end
    end
    always_ff @(posedge clk) last_r <= pin;
endmodule : pcg_pin_model
`default_nettype wire

// [test/port_crossbar_gpio_control_tb.sv]
// Self-checking bench for the port crossbar and general-purpose I/O block
`timescale 1ns/1ps
`default_nettype none
module port_crossbar_gpio_control_tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, sfr_rdata;
    logic       sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, bit_rdata;
    logic       bit_wr = 1'b0, bit_wdata = 1'b0, bit_rd = 1'b0, bit_rmw = 1'b0;
    logic [7:0] p0_in, p0_out, p0_oe_n, p0_pu, p4_in, p4_out, p4_oe_n, p4_pu;
    logic [7:0] ext0_en = 8'h00;
    logic       smbus_route = 1'b0, sda_low = 1'b0, scl_low = 1'b0;
    logic [4:0] compare_out = 5'h00;
    logic       sda_in, scl_in, t0_in, t1_in, eci_in, b;
    int         miscompares = 0;
    int         n_compared = 0;

    pcg_port_xbar uut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
        .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata), .bit_rd(bit_rd),
        .bit_rmw(bit_rmw), .bit_rdata(bit_rdata), .port0_pin_in(p0_in),
        .port0_pin_out(p0_out), .port0_pin_oe_n(p0_oe_n), .port0_pullup_en(p0_pu),
        .port4_pin_in(p4_in), .port4_pin_out(p4_out), .port4_pin_oe_n(p4_oe_n),
        .port4_pullup_en(p4_pu), .smbus_route(smbus_route), .sda_drive_low(sda_low),
        .scl_drive_low(scl_low), .compare_out(compare_out), .sda_in(sda_in),
        .scl_in(scl_in), .timer0_in(t0_in), .timer1_in(t1_in),
        .counter_ext_clock_in(eci_in));
    pcg_pin_model pins0 (.clk(clk), .out(p0_out), .oe_n(p0_oe_n), .pull(p0_pu),
        .ext_en(ext0_en), .ext_val(8'h00), .pin(p0_in));
    pcg_pin_model pins4 (.clk(clk), .out(p4_out), .oe_n(p4_oe_n), .pull(p4_pu),
        .ext_en(8'h00), .ext_val(8'h00), .pin(p4_in));

    initial begin
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        @(negedge clk);
    endtask : sfr_write
    task automatic rd_chk(input logic [7:0] a, input logic m, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rmw  <= m;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd  <= 1'b0;
        sfr_rmw <= 1'b0;
        @(negedge clk);
        check(sfr_rdata, exp);
    endtask : rd_chk
    task automatic bit_op(input logic [7:0] a, input logic w, v, m, output logic d);
        @(posedge clk);
        bit_addr  <= a;
        bit_wdata <= v;
        bit_wr    <= w;
        bit_rd    <= !w;
        bit_rmw   <= m;
        @(posedge clk);
        bit_wr <= 1'b0;
        bit_rd <= 1'b0;
        @(negedge clk);
        d = bit_rdata;
    endtask : bit_op
    // Two-flop pin sampling needs a few edges before reads see a change
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(p0_oe_n, 8'hFF);
        check(p0_pu, 8'hFF);
        check(p4_oe_n, 8'hFF);
        // Synchroniser still holds its reset zeros for two edges after release
        settle();
        rd_chk(8'h80, 1'b0, 8'hFF);
        rd_chk(8'hA4, 1'b0, 8'h00);
        rd_chk(8'hE2, 1'b0, 8'h00);
        rd_chk(pcg_pkg::ADDR_PORT0_INMODE, 1'b0, 8'hFF);
        rd_chk(8'h55, 1'b0, 8'h00);
    endtask : t_reset
    task automatic t_drive;
        sfr_write(8'hE2, 8'h40);
        sfr_write(8'h80, 8'h5A);
        check(p0_oe_n, 8'h5A);
        check(p0_out & ~p0_oe_n, 8'h00);
        check(p0_pu, 8'h5A);
        sfr_write(8'hA4, 8'hFF);
        rd_chk(8'hA4, 1'b0, 8'hFF);
        check(p0_oe_n, 8'h00);
        check(p0_out, 8'h5A);
        check(p0_pu, 8'h00);
        settle();
        rd_chk(8'h80, 1'b0, 8'h5A);
        sfr_write(8'hE2, 8'h00);
        check(p0_oe_n, 8'hFF);
        sfr_write(8'hA4, 8'h00);
        sfr_write(8'h80, 8'hFF);
    endtask : t_drive
    task automatic t_pullup;
        sfr_write(8'hE2, 8'hC0);
        rd_chk(8'hE2, 1'b0, 8'hC0);
        check(p0_pu, 8'h00);
        check(p4_pu, 8'h00);
        sfr_write(8'hE2, 8'h40);
        check(p0_pu, 8'hFF);
    endtask : t_pullup
    task automatic t_rmw;
        @(posedge clk);
        ext0_en <= 8'h3C;
        settle();
        rd_chk(8'h80, 1'b0, 8'hC3);
        rd_chk(8'h80, 1'b1, 8'hFF);
        bit_op(8'h82, 1'b0, 1'b0, 1'b0, b);
        check(b, 8'h00);
        bit_op(8'h82, 1'b0, 1'b0, 1'b1, b);
        check(b, 8'h01);
        bit_op(8'h83, 1'b1, 1'b0, 1'b0, b);
        rd_chk(8'h80, 1'b1, 8'hF7);
        bit_op(8'h90, 1'b1, 1'b0, 1'b0, b);
        rd_chk(8'h80, 1'b1, 8'hF7);
        @(posedge clk);
        ext0_en <= 8'h00;
        sfr_write(8'h80, 8'hFF);
        sfr_write(pcg_pkg::ADDR_PORT4_LATCH, 8'h3C);
        check(p4_oe_n, 8'h3C);
        check(p4_out, 8'h3C);
        check(p4_pu, 8'h3C);
        settle();
        rd_chk(pcg_pkg::ADDR_PORT4_LATCH, 1'b0, 8'h3C);
        sfr_write(pcg_pkg::ADDR_PORT4_LATCH, 8'hFF);
    endtask : t_rmw
    task automatic t_compare;
        logic [7:0] exp;
        for (int n = 0; n < 8; n++) begin
            sfr_write(8'hE2, 8'h40 | 8'(n));
            exp = (n > 5) ? 8'hFF : ~((8'h01 << n) - 8'h01);
            check(p0_oe_n, exp);
        end
        sfr_write(8'hE2, 8'h45);
        @(posedge clk);
        compare_out <= 5'h0A;
        @(negedge clk);
        check(p0_oe_n, 8'hEA);
        @(posedge clk);
        compare_out <= 5'h00;
    endtask : t_compare
    task automatic t_inputs;
        sfr_write(8'h80, 8'h00);
        sfr_write(8'hE2, 8'h78);
        check(p0_oe_n, 8'h07);
        @(posedge clk);
        ext0_en <= 8'h02;
        settle();
        check({5'h00, eci_in, t0_in, t1_in}, 8'h05);
        @(posedge clk);
        ext0_en <= 8'h05;
        settle();
        check({5'h00, eci_in, t0_in, t1_in}, 8'h02);
        sfr_write(8'hE2, 8'h40);
        settle();
        check({5'h00, eci_in, t0_in, t1_in}, 8'h00);
        @(posedge clk);
        ext0_en <= 8'h00;
        sfr_write(8'h80, 8'hFF);
    endtask : t_inputs
    task automatic t_smbus;
        @(posedge clk);
        smbus_route <= 1'b1;
        sfr_write(8'hA4, 8'hFF);
        check({6'h00, p0_oe_n[1:0]}, 8'h03);
        @(posedge clk);
        sda_low <= 1'b1;
        settle();
        check({p0_oe_n[0], p0_out[0]}, 8'h00);
        check({6'h00, sda_in, scl_in}, 8'h01);
        @(posedge clk);
        sda_low     <= 1'b0;
        smbus_route <= 1'b0;
        sfr_write(8'hA4, 8'h00);
    endtask : t_smbus
    task automatic t_analog;
        sfr_write(8'h80, 8'hFE);
        sfr_write(pcg_pkg::ADDR_PORT0_INMODE, 8'hFE);
        check({p0_pu[0], p0_oe_n[0]}, 8'h01);
        settle();
        rd_chk(8'h80, 1'b0, 8'hFE);
        sfr_write(pcg_pkg::ADDR_PORT0_INMODE, 8'hFF);
        sfr_write(8'h80, 8'hFF);
    endtask : t_analog
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_drive();
        t_pullup();
        t_rmw();
        t_compare();
        t_inputs();
        t_smbus();
        t_analog();
        finish_test();
    end
    // Guards against a hang anywhere in the sequence
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule : port_crossbar_gpio_control_tb
`default_nettype wire
